// file: common/quu_pkg.sv
// Shared constants for the quad byte unpack unit.
package quu_pkg;
    // Data register geometry.
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned HALF_W    = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned NUM_DREG  = 8;
    localparam int unsigned OFS_W     = 2;
    localparam int unsigned WIN_BYTES = 8;
    localparam int unsigned PICK_N    = 4;
    // Lower register index of each legal source pair.
    localparam logic [2:0]  PAIR_A_LO = 3'h0;
    localparam logic [2:0]  PAIR_B_LO = 3'h2;
    // Position of the alignment bits inside the index register.
    localparam int unsigned OFS_LSB   = 0;
    // Values after reset.
    localparam logic [31:0] WORD_RST  = 32'h0;
    localparam logic        FLAG_RST  = 1'b0;
endpackage

// file: common/quu_sel_if.sv
// Carrier between the unpack control and its byte selector.
`timescale 1ns/10ps
interface quu_sel_if;
    logic [31:0] lower_word;  // Lower-numbered register of the pair.
    logic [31:0] upper_word;  // Higher-numbered register of the pair.
    logic        reverse;     // Swap the pair within the window.
    logic [1:0]  offset;      // Starting byte inside the window.
    logic [31:0] dest0_word;  // Result for the second-named target.
    logic [31:0] dest1_word;  // Result for the first-named target.

    modport ctrl (
        output lower_word, upper_word, reverse, offset,
        input  dest0_word, dest1_word
    );
    modport sel (
        input  lower_word, upper_word, reverse, offset,
        output dest0_word, dest1_word
    );
endinterface

// file: rtl/quu_byte_select.sv
// Byte window selector and half-word spreader of the unpack unit.
`timescale 1ns/10ps
module quu_byte_select (
    // Operands in, results out.
    quu_sel_if.sel sel_if
);
    // Eight-byte window and the four picked bytes.
    logic [7:0] win_b  [8];
    logic [7:0] pick_b [4];

    // Build the window; reverse only swaps which word forms the low half.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (sel_if.reverse) begin  // see [RQ4]
                win_b[i]     = sel_if.upper_word[i*8 +: 8];
                win_b[i + 4] = sel_if.lower_word[i*8 +: 8];
            end else begin  // see [RQ3]
                win_b[i]     = sel_if.lower_word[i*8 +: 8];
                win_b[i + 4] = sel_if.upper_word[i*8 +: 8];
            end
        end
    end

    // Four consecutive bytes starting at the alignment offset.
    for (genvar k = 0; k < 4; k++) begin : g_pick
        logic [2:0] idx;
        assign idx       = {1'b0, sel_if.offset} + 3'(k);  // see [RQ2]
        assign pick_b[k] = win_b[idx];  // see [RQ1]
    end

    // Each byte is zero-extended into its own half-word.
    assign sel_if.dest0_word =
        {8'h00, pick_b[1], 8'h00, pick_b[0]};  // see [RQ6]
    assign sel_if.dest1_word =
        {8'h00, pick_b[3], 8'h00, pick_b[2]};  // see [RQ6]
endmodule

// file: rtl/quu_unpack_core.sv
// Quad byte unpack unit: decode, data registers and write-back.
//
// Behaviour
// [RQ1] Pick four consecutive bytes from eight-byte window.
// [RQ2] Index register bits 1:0 set start byte.
// [RQ3] Default: lower register gives window bytes 0..3.
// [RQ4] Reverse: higher register gives window bytes 0..3.
// [RQ5] Write bytes to any two data registers.
// [RQ6] Zero-extend; first pair to second-named target.
// [RQ7] Only R1:0 or R3:2 are legal sources.
// [RQ8] Suppress misaligned load exception during the unpack.
// [RQ9] Accept the unpack only as 32-bit word.
// [RQ10] Execute alongside permitted parallel 16-bit loads.
`timescale 1ns/10ps
module quu_unpack_core #(
    parameter int unsigned NUM_DREG = quu_pkg::NUM_DREG,
    parameter int unsigned IDX_W    = $clog2(NUM_DREG)
) (
    // Clock and synchronous reset.
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Unpack issue from the instruction decoder.
    input  wire logic             op_valid_i,
    input  wire logic             op_len32_i,
    input  wire logic             op_reverse_i,
    input  wire logic [IDX_W-1:0] src_pair_i,
    input  wire logic [IDX_W-1:0] dst1_idx_i,
    input  wire logic [IDX_W-1:0] dst0_idx_i,
    input  wire logic [31:0]      index_reg_zero_i,
    // Parallel 16-bit load in the same packet.
    input  wire logic             ld_valid_i,
    input  wire logic [IDX_W-1:0] ld_idx_i,
    input  wire logic [31:0]      ld_data_i,
    input  wire logic             ld_misaligned_i,
    // Write-back of the unpack results.
    output logic                  wb_valid_o,
    output logic [IDX_W-1:0]      wb_dst0_idx_o,
    output logic [31:0]           wb_dst0_data_o,
    output logic [IDX_W-1:0]      wb_dst1_idx_o,
    output logic [31:0]           wb_dst1_data_o,
    // Error and exception reports.
    output logic                  misalign_exc_o,
    output logic                  decode_err_o,
    output logic                  pair_err_o
);
    // The legal pairs reach register 3, and indices must wrap cleanly.
    if (NUM_DREG < 4 || (1 << IDX_W) != NUM_DREG) begin : g_bad_cfg
        $error("NUM_DREG must be a power of two of at least four");
    end

    // General data registers; datapath only, so left without reset.
    logic [31:0]      dreg_q [NUM_DREG];
    // Decoded issue qualifiers.
    logic             op_long;    // Unpack in its 32-bit form.
    logic             pair_ok;    // Source pair is one of the legal two.
    logic             unpack_go;  // Unpack really executes this cycle.
    logic [IDX_W-1:0] upper_idx;  // Higher-numbered register of the pair.
    // Link to the byte selector.
    quu_sel_if        sel_if ();

    // A short-form word with the unpack opcode is never executed.
    assign op_long   = op_valid_i & op_len32_i;  // see [RQ9]
    // Any other pair base is an issue-side fault and is dropped.
    assign pair_ok   = (src_pair_i == IDX_W'(quu_pkg::PAIR_A_LO)) ||
                       (src_pair_i == IDX_W'(quu_pkg::PAIR_B_LO));  // see [RQ7]
    assign unpack_go = op_long & pair_ok;
    // Pair bases are even, so the partner just sets bit zero.
    assign upper_idx = {src_pair_i[IDX_W-1:1], 1'b1};

    // Operands are read before any write of this packet lands, so a
    // parallel refill of the pair serves the next unpack, not this one.
    assign sel_if.lower_word = dreg_q[src_pair_i];
    assign sel_if.upper_word = dreg_q[upper_idx];
    assign sel_if.reverse    = op_reverse_i;
    // Only the two alignment bits of the index register are looked at.
    assign sel_if.offset     =
        index_reg_zero_i[quu_pkg::OFS_LSB +: 2];  // see [RQ2]

    // Byte window selection and spreading.
    quu_byte_select u_sel (
        .sel_if (sel_if)
    );

    // Register file update: the load lands first, then the unpack results,
    // so an unpack target named by the load as well keeps the unpack value.
    always_ff @(posedge clk_i) begin
        if (ld_valid_i) begin  // see [RQ10]
            dreg_q[ld_idx_i] <= ld_data_i;
        end
        if (unpack_go) begin  // see [RQ5]
            dreg_q[dst0_idx_i] <= sel_if.dest0_word;
            dreg_q[dst1_idx_i] <= sel_if.dest1_word;
        end
    end

    // Write-back report, registered one cycle after issue.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wb_valid_o     <= quu_pkg::FLAG_RST;
            wb_dst0_idx_o  <= '0;
            wb_dst0_data_o <= quu_pkg::WORD_RST;
            wb_dst1_idx_o  <= '0;
            wb_dst1_data_o <= quu_pkg::WORD_RST;
        end else begin
            wb_valid_o <= unpack_go;  // see [RQ5]
            // Results hold their last value while no unpack executes.
            if (unpack_go) begin
                wb_dst0_idx_o  <= dst0_idx_i;
                wb_dst0_data_o <= sel_if.dest0_word;  // see [RQ6]
                wb_dst1_idx_o  <= dst1_idx_i;
                wb_dst1_data_o <= sel_if.dest1_word;  // see [RQ6]
            end
        end
    end

    // Exception and error pulses.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            misalign_exc_o <= quu_pkg::FLAG_RST;
            decode_err_o   <= quu_pkg::FLAG_RST;
            pair_err_o     <= quu_pkg::FLAG_RST;
        end else begin
            // Any 32-bit unpack masks the fault, even one later refused
            // for its pair, since the load was issued to feed it.
            misalign_exc_o <= ld_valid_i & ld_misaligned_i
                              & ~op_long;  // see [RQ8]
            decode_err_o   <= op_valid_i & ~op_len32_i;  // see [RQ9]
            pair_err_o     <= op_long & ~pair_ok;  // see [RQ7]
        end
    end

    // Checks on the datapath and its reports.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_short_refused: assert property ( // see [RQ9]
        op_valid_i && !op_len32_i |=> decode_err_o && !wb_valid_o)
        else $error("short-form unpack was not refused");

    chk_pair_refused: assert property ( // see [RQ7]
        op_long && !pair_ok |=> pair_err_o && !wb_valid_o)
        else $error("illegal source pair was executed");

    chk_wb_follows: assert property ( // see [RQ5]
        unpack_go |=> wb_valid_o && wb_dst1_idx_o == $past(dst1_idx_i))
        else $error("unpack result not reported next cycle");

    chk_zero_extend: assert property ( // see [RQ6]
        wb_valid_o |-> wb_dst0_data_o[31:24] == 8'h00 &&
                       wb_dst0_data_o[15:8] == 8'h00 &&
                       wb_dst1_data_o[31:24] == 8'h00 &&
                       wb_dst1_data_o[15:8] == 8'h00)
        else $error("result bytes not zero-extended");

    chk_default_order: assert property ( // see [RQ3]
        unpack_go && !op_reverse_i && sel_if.offset == 2'h0
        |=> wb_dst0_data_o[7:0] == $past(sel_if.lower_word[7:0]) &&
            wb_dst1_data_o[23:16] == $past(sel_if.lower_word[31:24]))
        else $error("default order picked wrong bytes");

    chk_reverse_order: assert property ( // see [RQ4]
        unpack_go && op_reverse_i && sel_if.offset == 2'h1
        |=> wb_dst0_data_o[7:0] == $past(sel_if.upper_word[15:8]) &&
            wb_dst1_data_o[23:16] == $past(sel_if.lower_word[7:0]))
        else $error("reverse order picked wrong bytes");

    chk_offset_three: assert property ( // see [RQ1]
        unpack_go && !op_reverse_i && sel_if.offset == 2'h3
        |=> wb_dst0_data_o[7:0] == $past(sel_if.lower_word[31:24]) &&
            wb_dst1_data_o[23:16] == $past(sel_if.upper_word[23:16]))
        else $error("offset three window wrong");

    chk_exc_masked: assert property ( // see [RQ8]
        ld_valid_i && ld_misaligned_i
        |=> misalign_exc_o == !$past(op_long))
        else $error("misaligned load exception mishandled");

    chk_dest_written: assert property ( // see [RQ5]
        wb_valid_o |-> dreg_q[wb_dst1_idx_o] == wb_dst1_data_o)
        else $error("unpack target register not written");

    chk_parallel_load: assert property ( // see [RQ10]
        unpack_go && ld_valid_i && ld_idx_i != dst0_idx_i &&
        ld_idx_i != dst1_idx_i
        |=> dreg_q[$past(ld_idx_i)] == $past(ld_data_i))
        else $error("parallel load lost beside unpack");

    chk_offset_two: assert property ( // see [RQ2]
        unpack_go && !op_reverse_i && sel_if.offset == 2'h2
        |=> wb_dst0_data_o[7:0] == $past(sel_if.lower_word[23:16]) &&
            wb_dst1_data_o[23:16] == $past(sel_if.upper_word[15:8]))
        else $error("offset two window wrong");

    // The middle bytes land in the other halves of each target.
    chk_middle_bytes: assert property ( // see [RQ1]
        unpack_go && !op_reverse_i && sel_if.offset == 2'h1
        |=> wb_dst0_data_o[23:16] == $past(sel_if.lower_word[23:16]) &&
            wb_dst1_data_o[7:0] == $past(sel_if.lower_word[31:24]))
        else $error("middle bytes of the window wrong");

    chk_reverse_zero: assert property ( // see [RQ4]
        unpack_go && op_reverse_i && sel_if.offset == 2'h0
        |=> wb_dst0_data_o[7:0] == $past(sel_if.upper_word[7:0]) &&
            wb_dst1_data_o[23:16] == $past(sel_if.upper_word[31:24]))
        else $error("reverse order at offset zero wrong");

    // Nothing is reported for a cycle in which no unpack executed.
    chk_idle_quiet: assert property ( // see [RQ5]
        !unpack_go |=> !wb_valid_o)
        else $error("write-back reported without an unpack");

    // Reported results hold between unpacks, so a late reader is safe.
    chk_result_held: assert property ( // see [RQ5]
        !unpack_go |=> $stable(wb_dst0_data_o) && $stable(wb_dst1_data_o))
        else $error("write-back data moved without an unpack");

    // The second-named target is written unless the first one is the same.
    chk_dst0_written: assert property ( // see [RQ5]
        wb_valid_o && wb_dst0_idx_o != wb_dst1_idx_o
        |-> dreg_q[wb_dst0_idx_o] == wb_dst0_data_o)
        else $error("second-named target register not written");

    // A load with no unpack beside it lands at its own issue edge.
    chk_load_lands: assert property ( // see [RQ10]
        ld_valid_i && !unpack_go
        |=> dreg_q[$past(ld_idx_i)] == $past(ld_data_i))
        else $error("load data not written");

    // The exception pulse is owed only to a misaligned load.
    chk_exc_needs_load: assert property ( // see [RQ8]
        !ld_valid_i |=> !misalign_exc_o)
        else $error("misaligned exception without a load");

    // Error pulses need an unpack opcode in the packet.
    chk_err_needs_op: assert property ( // see [RQ9]
        !op_valid_i |=> !decode_err_o && !pair_err_o)
        else $error("error pulse without an unpack opcode");
endmodule

// file: testbench/quu_issue_model.sv
// Issue-side partner model: drives unpack packets and parallel loads.
`timescale 1ns/10ps
module quu_issue_model (
    // Core clock.
    input  wire logic        clk_i,
    // Unpack packet towards the unit.
    output logic             op_valid_o,
    output logic             op_len32_o,
    output logic             op_reverse_o,
    output logic [2:0]       src_pair_o,
    output logic [2:0]       dst1_idx_o,
    output logic [2:0]       dst0_idx_o,
    output logic [31:0]      idx0_o,
    // Parallel load in the same packet.
    output logic             ld_valid_o,
    output logic [2:0]       ld_idx_o,
    output logic [31:0]      ld_data_o,
    output logic             ld_mis_o
);
    // All lines start quiet so nothing is issued during reset.
    initial {op_valid_o, op_len32_o, op_reverse_o, src_pair_o, dst1_idx_o,
             dst0_idx_o, idx0_o, ld_valid_o, ld_idx_o, ld_data_o,
             ld_mis_o} = '0;

    // One packet per call, launched at the falling edge and held a cycle.
    task automatic step(input logic op, len, rev, input logic [2:0] pr,
            d1, d0, input logic [1:0] off, input logic ldv,
            input logic [2:0] ldi, input logic [31:0] ldd, input logic mis);
        @(negedge clk_i);
        op_valid_o   = op;
        op_len32_o   = len;
        op_reverse_o = rev;
        src_pair_o   = pr;
        dst1_idx_o   = d1;
        dst0_idx_o   = d0;
        // Upper index bits carry junk, so only the offset may matter.
        idx0_o       = {30'h1234567, off};
        ld_valid_o   = ldv;
        ld_idx_o     = ldi;
        // An idle load bus shows flipped data, never the last word.
        ld_data_o    = ldv ? ldd : ~ld_data_o;
        ld_mis_o     = mis;
        @(posedge clk_i);
        #10;
    endtask
endmodule

// file: testbench/quu_unpack_core_test.sv
// Self-checking bench for the quad byte unpack unit.
`timescale 1ns/10ps
module quu_unpack_core_test;
    logic        clk_i, srst_i, op_valid, op_len32, op_rev, ld_valid, ld_mis;
    logic        wb_valid, mis_exc, dec_err, pair_err;
    logic [2:0]  src_pair, dst1, dst0, ld_idx, wb_i0, wb_i1;
    logic [31:0] idx0, ld_data, wb_d0, wb_d1;
    logic [31:0] regs [4];   // Shadow of the source registers.
    int          n_fail, checks_done;

    quu_issue_model i_issue (.clk_i(clk_i), .op_valid_o(op_valid),
        .op_len32_o(op_len32), .op_reverse_o(op_rev), .src_pair_o(src_pair),
        .dst1_idx_o(dst1), .dst0_idx_o(dst0), .idx0_o(idx0),
        .ld_valid_o(ld_valid), .ld_idx_o(ld_idx), .ld_data_o(ld_data),
        .ld_mis_o(ld_mis));
    quu_unpack_core i_dut (.clk_i(clk_i), .srst_i(srst_i),
        .op_valid_i(op_valid), .op_len32_i(op_len32), .op_reverse_i(op_rev),
        .src_pair_i(src_pair), .dst1_idx_i(dst1), .dst0_idx_i(dst0),
        .index_reg_zero_i(idx0), .ld_valid_i(ld_valid), .ld_idx_i(ld_idx),
        .ld_data_i(ld_data), .ld_misaligned_i(ld_mis), .wb_valid_o(wb_valid),
        .wb_dst0_idx_o(wb_i0), .wb_dst0_data_o(wb_d0), .wb_dst1_idx_o(wb_i1),
        .wb_dst1_data_o(wb_d1), .misalign_exc_o(mis_exc),
        .decode_err_o(dec_err), .pair_err_o(pair_err));

    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;

    // Compare one value and count it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Flags in order: write-back, pair error, decode error, misalign.
    task automatic flags(input logic [3:0] exp);
        chk({28'h0, wb_valid, pair_err, dec_err, mis_exc}, {28'h0, exp});
    endtask

    // Expected {first-named, second-named} words from the shadow copy.
    function automatic logic [63:0] expect_pair(input logic [2:0] pr,
            input logic rev, input logic [1:0] off);
        logic [63:0] sh;
        sh = rev ? {regs[pr], regs[pr + 3'h1]} : {regs[pr + 3'h1], regs[pr]};
        sh = sh >> {off, 3'b000};
        return {8'h0, sh[31:24], 8'h0, sh[23:16],
                8'h0, sh[15:8], 8'h0, sh[7:0]};
    endfunction

    // Fill the four source registers through the load port.
    task automatic t_load();
        regs = '{32'hbeefbadd, 32'hfeedface, 32'h01234567, 32'h89abcdef};
        for (int r = 0; r < 4; r++) begin
            i_issue.step(0, 0, 0, 0, 0, 0, 0, 1, r[2:0], regs[r], 0);
        end
    endtask

    // Both legal pairs, every order and offset, issued back to back.
    task automatic t_unpack_all();
        logic [63:0] e;
        logic [2:0]  pr;
        for (int i = 0; i < 16; i++) begin
            // Only the two legal pair bases, 0 and 2, are issued here.
            pr = {1'b0, i[3], 1'b0};
            i_issue.step(1, 1, i[2], pr, 3'h6 + i[3], 3'h5 - i[3],
                         i[1:0], 0, 0, 0, 0);
            e = expect_pair(pr, i[2], i[1:0]);
            flags(4'h8);
            chk({29'h0, wb_i1}, 32'h6 + i[3]);
            chk({29'h0, wb_i0}, 32'h5 - i[3]);
            chk(wb_d0, e[31:0]);
            chk(wb_d1, e[63:32]);
        end
    endtask

    // Refused forms write nothing; the long form still hides the fault.
    task automatic t_refuse();
        i_issue.step(1, 0, 0, 0, 6, 5, 0, 0, 0, 0, 0);
        flags(4'h2);
        i_issue.step(1, 1, 0, 1, 6, 5, 0, 1, 7, 32'h5a5a5a5a, 1);
        flags(4'h4);
        i_issue.step(1, 1, 1, 3, 6, 5, 2, 0, 0, 0, 0);
        flags(4'h4);
        i_issue.step(0, 0, 0, 0, 0, 0, 0, 1, 7, 32'h0, 1);
        flags(4'h1);
        i_issue.step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        flags(4'h0);
    endtask

    // Refill a source in the same packet: old value now, new value next.
    task automatic t_parallel();
        logic [63:0] e;
        i_issue.step(1, 1, 0, 0, 6, 5, 1, 1, 0, 32'h13579bdf, 1);
        e = expect_pair(0, 0, 1);
        flags(4'h8);
        chk(wb_d0, e[31:0]);
        regs[0] = 32'h13579bdf;
        i_issue.step(1, 1, 1, 0, 6, 5, 3, 0, 0, 0, 0);
        e = expect_pair(0, 1, 3);
        chk(wb_d1, e[63:32]);
    endtask

    // Print counts and the verdict, then stop.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence after twenty cycles of reset.
    initial begin
        srst_i = 1'b1;
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        t_load();
        t_unpack_all();
        t_refuse();
        t_parallel();
        print_verdict();
    end

    // Twenty-seven packets follow twenty reset cycles; over thirty times that span means a hang.
    initial begin
        #150000;
        n_fail++;
        print_verdict();
    end
endmodule
